// >>> include/motion_consts.svh
// constants of the motion state priority encoder
`ifndef MOTION_CONSTS_SVH
`define MOTION_CONSTS_SVH

`define POS_W          16
`define SAFE_W         11
`define SAFE_SHIFT     5
`define SAFE_DISABLED  11'h400
`define PRM_W          4
`define SYNC_W         5
`define GOAL_RESET     16'h0000
`define PRM_RESET      4'h0

`endif

// >>> include/motion_pkg.sv
// types of the motion state priority encoder
`include "motion_consts.svh"

package motion_pkg;

	typedef enum logic [2:0] {
		S_STOPPED,
		S_MOVING_TO_TARGET,
		S_REFERENCE_RUN,
		S_DECELERATING_HALT,
		S_FORCED_HALT,
		S_SHUTDOWN,
		S_SLEEP
	} motion_state_e;

	// one-cycle command strobes from the frame decoder
	typedef struct packed {
		logic write_target;
		logic write_target_short;
		logic go_safe_target_cmd;
		logic reference_run;
		logic forced_halt;
		logic decelerating_halt;
		logic sleep_req;
		logic bus_timeout;
		logic read_status;
		logic read_full_status;
		logic reload_defaults;
		logic write_motion_params;
		logic clear_positions;
		logic assign_id;
	} cmd_s;

	typedef struct packed {
		logic [`PRM_W-1:0] vmax;
		logic [`PRM_W-1:0] vmin;
		logic [`PRM_W-1:0] acc;
	} params_s;

	// optional fields carried by a reference run command
	typedef struct packed {
		logic              vmax_given;
		logic [`PRM_W-1:0] vmax;
		logic              vmin_given;
		logic [`PRM_W-1:0] vmin;
	} run_cmd_s;

endpackage

// >>> verilog/sync_2ff.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_st_s;

	sync_st_s st_r;
	sync_st_s st_nxt;

	// first stage feeds only the second
	always_comb begin
		st_nxt.meta   = async_in;
		st_nxt.stable = st_r.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stable;

endmodule

// >>> verilog/motion_state_priority_encoder.sv
// main control state machine of the stepper position controller
//
// Functional notes
// - short target write in stopped moves; in motion/run only goal updates; half-step only
// - go-safe-target loads goal from safe target when valid; moves from stopped
// - sleep or timeout while moving: goal=safe target if valid, else decelerate
// - sleep during run loads safe target; stop states act on sleep when stopped
// - pump, battery or electrical fault sets halt flag; shutdown or forced halt
// - over-temperature: stopped to shutdown, moving or run to decelerating halt
// - motion done returns to stopped; halt states copy current into goal
// - leaving sleep equals a full power-on reset
// - after reset enter shutdown; leave for stopped only after a full status read
// - shutdown held until over-temperature and fault halt flags are clear, unless sleep or timeout goes to sleep
// - reference run uses own parameters; missing ones copied from working RAM
// - ramp profile forced to one in second run motion; reload deferred
// - sleep flag set by timeout or sleep, cleared by next command
// - fault and over-temperature flags cleared on status read with normal conditions or on wake; step-loss on any read
// - parameters written during run take effect at next target command
// - stopped with sleep flag: sleep or move to safe target
// - safe target valid unless it holds the most negative code
// - stop flag set leaving halt states, cleared first edge in stopped
// - identifier assignment decoded except in sleep, state unchanged
// - position mismatch in stopped moves, lowest priority
// - missed-step flag blocks goal writes, sleep direct, read clears it
// - decelerating halt request while moving; ignored during run
// - position set in stopped moves; clear positions in stopped or shutdown
`timescale 1ns/1ps

module motion_state_priority_encoder
	import motion_pkg::*;
(
	// clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    reset,
	// commands from the frame decoder
	input  wire cmd_s                    cmd,
	input  wire logic [`POS_W-1:0]       cmd_position,
	input  wire run_cmd_s                run_cmd,
	input  wire logic                    half_step_mode,
	// motion datapath
	input  wire logic [`POS_W-1:0]       current_position,
	input  wire logic                    motion_done,
	input  wire logic                    run_second_motion,
	// working RAM
	input  wire logic [`SAFE_W-1:0]      safe_target,
	input  wire params_s                 ram_params,
	input  wire logic                    ram_profile_select,
	// raw condition pins
	input  wire logic                    cp_fail_pin,
	input  wire logic                    low_battery_pin,
	input  wire logic                    elec_defect_pin,
	input  wire logic                    over_temp_pin,
	input  wire logic                    wake_pin,
	// state and flags
	output motion_state_e                state_r,
	output logic [`POS_W-1:0]            goal_position_r,
	output logic                         sleep_flag_r,
	output logic                         stop_flag_r,
	output logic                         fault_halt_flag_r,
	output logic                         over_temp_flag_r,
	output logic                         step_loss_flag_r,
	output logic                         power_on_flag_r,
	output logic                         safe_target_valid_r,
	// datapath control
	output logic                         clear_current_r,
	output logic                         id_assign_r,
	output logic                         ramp_profile_select_r,
	output params_s                      run_params_r,
	output params_s                      active_params_r
);

	typedef struct packed {
		motion_state_e     state;
		logic [`POS_W-1:0] goal;
		logic              sleep;
		logic              stop;
		logic              hs;
		logic              tsd;
		logic              steploss;
		logic              por;
		logic              secen;
		logic              clr_cur;
		logic              id_pulse;
		logic              prof_base;
		logic              prof_sel;
		logic              reload_pend;
		params_s           run_prm;
		params_s           act_prm;
	} st_s;

	localparam st_s ST_RESET = '{
		state: S_SHUTDOWN, goal: `GOAL_RESET, sleep: 1'b0, stop: 1'b0,
		hs: 1'b0, tsd: 1'b0, steploss: 1'b0, por: 1'b1, secen: 1'b0,
		clr_cur: 1'b0, id_pulse: 1'b0, prof_base: 1'b0, prof_sel: 1'b0,
		reload_pend: 1'b0, run_prm: '0, act_prm: '0
	};

	st_s                st_r;
	st_s                st_nxt;
	logic [`SYNC_W-1:0] pins_s;
	logic               fault_now;
	logic               ot_now;
	logic               wake_now;
	logic               normal;
	logic               rd;
	logic               sleep_ev;
	logic               other_cmd;
	logic               secen;
	logic               goal_wr;
	logic [`POS_W-1:0]  safe_pos;
	logic               tgt_any;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	sync_2ff #(.WIDTH(`SYNC_W)) u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({wake_pin, over_temp_pin, elec_defect_pin, low_battery_pin, cp_fail_pin}),
		.sync_out (pins_s)
	);

	////////////////////////////////////////////////////////////////////////
	// decoded events

	assign fault_now = pins_s[0] | pins_s[1] | pins_s[2];
	assign ot_now    = pins_s[3];
	assign wake_now  = pins_s[4];
	assign normal    = ~fault_now & ~ot_now;
	assign rd        = cmd.read_status | cmd.read_full_status;
	assign sleep_ev  = cmd.sleep_req | cmd.bus_timeout;
	assign other_cmd = cmd.write_target | cmd.write_target_short | cmd.go_safe_target_cmd
		| cmd.reference_run | cmd.forced_halt | cmd.decelerating_halt | rd
		| cmd.reload_defaults | cmd.write_motion_params | cmd.clear_positions
		| cmd.assign_id;
	assign secen     = safe_target != `SAFE_DISABLED;
	assign safe_pos  = {safe_target, {`SAFE_SHIFT{1'b0}}};
	assign goal_wr   = cmd.write_target | (cmd.write_target_short & half_step_mode);
	assign tgt_any   = cmd.write_target | cmd.write_target_short;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt          = st_r;
		st_nxt.clr_cur  = 1'b0;
		st_nxt.id_pulse = 1'b0;
		st_nxt.secen    = secen;

		st_nxt.hs  = fault_now | (st_r.hs & ~(rd & normal));
		st_nxt.tsd = ot_now | (st_r.tsd & ~(rd & normal));
		if (rd) begin
			st_nxt.steploss = 1'b0;
		end
		// power-on flag seen by full read
		if (cmd.read_full_status) begin
			st_nxt.por = 1'b0;
		end
		if (other_cmd) begin
			st_nxt.sleep = 1'b0;
		end
		if (sleep_ev) begin
			st_nxt.sleep = 1'b1;
		end
		if (st_r.state == S_STOPPED) begin
			st_nxt.stop = 1'b0;
		end
		if (cmd.assign_id && st_r.state != S_SLEEP) begin
			st_nxt.id_pulse = 1'b1;
		end

		case (st_r.state)
			S_STOPPED: begin
				if (fault_now || ot_now) begin
					st_nxt.state = S_SHUTDOWN;
				end else if (st_r.sleep) begin
					if (!secen || current_position == safe_pos || st_r.stop || st_r.steploss) begin
						st_nxt.state = S_SLEEP;
					end else begin
						st_nxt.goal  = safe_pos;
						st_nxt.state = S_MOVING_TO_TARGET;
					end
				end else if (goal_wr && !st_r.steploss) begin
					st_nxt.goal  = cmd_position;
					st_nxt.state = S_MOVING_TO_TARGET;
				end else if (cmd.go_safe_target_cmd && secen && !st_r.steploss) begin
					st_nxt.goal  = safe_pos;
					st_nxt.state = S_MOVING_TO_TARGET;
				end else if (cmd.reference_run) begin
					st_nxt.state = S_REFERENCE_RUN;
				end else if (cmd.clear_positions) begin
					st_nxt.goal    = `GOAL_RESET;
					st_nxt.clr_cur = 1'b1;
				end else if (current_position != st_r.goal) begin
					st_nxt.state = S_MOVING_TO_TARGET;
				end
			end
			S_MOVING_TO_TARGET, S_REFERENCE_RUN: begin
				if (fault_now) begin
					st_nxt.state = S_FORCED_HALT;
				end else if (ot_now) begin
					st_nxt.state = S_DECELERATING_HALT;
				end else if (sleep_ev) begin
					if (st_r.steploss) begin
						st_nxt.state = S_SLEEP;
					end else if (secen) begin
						st_nxt.goal = safe_pos;
					end else if (st_r.state == S_MOVING_TO_TARGET) begin
						st_nxt.state = S_DECELERATING_HALT;
					end
				end else if (cmd.forced_halt) begin
					st_nxt.state    = S_FORCED_HALT;
					st_nxt.steploss = 1'b1;
				end else if (cmd.decelerating_halt && st_r.state == S_MOVING_TO_TARGET) begin
					st_nxt.state = S_DECELERATING_HALT;
				end else if (goal_wr && !st_r.steploss) begin
					st_nxt.goal = cmd_position;
				end else if (cmd.go_safe_target_cmd && secen && !st_r.steploss) begin
					st_nxt.goal = safe_pos;
				end else if (motion_done) begin
					st_nxt.state = S_STOPPED;
				end
			end
			S_DECELERATING_HALT: begin
				if (fault_now) begin
					st_nxt.state = S_FORCED_HALT;
				end else if (cmd.forced_halt) begin
					st_nxt.state    = S_FORCED_HALT;
					st_nxt.steploss = 1'b1;
				end else if (motion_done) begin
					st_nxt.state = S_STOPPED;
					st_nxt.goal  = current_position;
					st_nxt.stop  = 1'b1;
				end
			end
			S_FORCED_HALT: begin
				if (motion_done) begin
					st_nxt.state = S_STOPPED;
					st_nxt.goal  = current_position;
					st_nxt.stop  = 1'b1;
				end
			end
			S_SHUTDOWN: begin
				if (sleep_ev) begin
					st_nxt.state = S_SLEEP;
				end else if ((cmd.read_full_status || (cmd.read_status && !st_r.por))
						&& !st_nxt.hs && !st_nxt.tsd) begin
					st_nxt.state = S_STOPPED;
				end else if (cmd.clear_positions) begin
					st_nxt.goal    = `GOAL_RESET;
					st_nxt.clr_cur = 1'b1;
				end
			end
			S_SLEEP: begin
				if (wake_now) begin
					st_nxt       = ST_RESET;
					// validity follows the stored target, as after power-up
					st_nxt.secen = secen;
				end
			end
			default: begin
				st_nxt.state = S_SHUTDOWN;
			end
		endcase

		if (st_r.state == S_STOPPED && st_nxt.state == S_REFERENCE_RUN) begin
			st_nxt.run_prm.vmax = run_cmd.vmax_given ? run_cmd.vmax : ram_params.vmax;
			st_nxt.run_prm.vmin = run_cmd.vmin_given ? run_cmd.vmin : ram_params.vmin;
			st_nxt.run_prm.acc  = ram_params.acc;
		end
		if (tgt_any || (cmd.write_motion_params && st_r.state != S_REFERENCE_RUN)) begin
			st_nxt.act_prm = ram_params;
		end
		if (cmd.write_motion_params) begin
			st_nxt.prof_base = ram_profile_select;
		end
		if (cmd.reload_defaults) begin
			if (st_r.state == S_REFERENCE_RUN) begin
				st_nxt.reload_pend = 1'b1;
			end else begin
				st_nxt.prof_base = 1'b0;
			end
		end
		if (st_r.reload_pend && st_nxt.state != S_REFERENCE_RUN) begin
			st_nxt.prof_base   = 1'b0;
			st_nxt.reload_pend = 1'b0;
		end
		st_nxt.prof_sel = (st_nxt.state == S_REFERENCE_RUN && run_second_motion)
			| st_nxt.prof_base;
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign state_r               = st_r.state;
	assign goal_position_r       = st_r.goal;
	assign sleep_flag_r          = st_r.sleep;
	assign stop_flag_r           = st_r.stop;
	assign fault_halt_flag_r     = st_r.hs;
	assign over_temp_flag_r      = st_r.tsd;
	assign step_loss_flag_r      = st_r.steploss;
	assign power_on_flag_r       = st_r.por;
	assign safe_target_valid_r   = st_r.secen;
	assign clear_current_r       = st_r.clr_cur;
	assign id_assign_r           = st_r.id_pulse;
	assign ramp_profile_select_r = st_r.prof_sel;
	assign run_params_r          = st_r.run_prm;
	assign active_params_r       = st_r.act_prm;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	logic quiet;
	assign quiet = ~fault_now & ~ot_now & ~st_r.sleep & ~sleep_ev;

	AST_SHORT_GOAL: assert property (
		st_r.state == S_STOPPED && quiet && cmd.write_target_short && half_step_mode
		&& !st_r.steploss |=> state_r == S_MOVING_TO_TARGET && goal_position_r == $past(cmd_position))
		else $error("short target write not taken");
	AST_SAFE_GO: assert property (
		st_r.state == S_STOPPED && quiet && !goal_wr && cmd.go_safe_target_cmd && secen
		&& !st_r.steploss |=> state_r == S_MOVING_TO_TARGET
		&& goal_position_r == {$past(safe_target), 5'h00})
		else $error("safe target not loaded");
	AST_FAULT_HALT: assert property (
		fault_now && st_r.state == S_MOVING_TO_TARGET |=> state_r == S_FORCED_HALT
		&& fault_halt_flag_r)
		else $error("fault did not force halt");
	AST_HEAT_SOFT: assert property (
		ot_now && !fault_now && st_r.state == S_REFERENCE_RUN |=> state_r == S_DECELERATING_HALT)
		else $error("over-temperature did not decelerate");
	AST_HALT_COPY: assert property (
		st_r.state == S_FORCED_HALT && motion_done |=> state_r == S_STOPPED
		&& goal_position_r == $past(current_position) && stop_flag_r ##1 !stop_flag_r)
		else $error("halt exit wrong");
	AST_SHUT_HOLD: assert property (
		st_r.state == S_SHUTDOWN && (fault_now || ot_now || ((st_r.hs || st_r.tsd) && !rd))
		|=> state_r inside {S_SHUTDOWN, S_SLEEP})
		else $error("shutdown left with fault");
	AST_SLEEP_SET: assert property (
		sleep_ev |=> sleep_flag_r)
		else $error("sleep flag not set");
	AST_SAFE_VALID: assert property (
		1'b1 |=> safe_target_valid_r == ($past(safe_target) != 11'h400))
		else $error("safe target valid wrong");
	AST_STEPLOSS_HOLD: assert property (
		st_r.steploss && st_r.state == S_MOVING_TO_TARGET && quiet && !motion_done
		|=> goal_position_r == $past(goal_position_r))
		else $error("goal changed with step loss");
	AST_RESET_SHUT: assert property (
		$fell(reset) |-> state_r == S_SHUTDOWN && power_on_flag_r)
		else $error("reset state wrong");

	COV_MOVE_DONE: cover property (st_r.state == S_MOVING_TO_TARGET && motion_done);
	COV_SLEEP: cover property (st_r.state == S_STOPPED ##1 state_r == S_SLEEP);
	COV_SHUT_EXIT: cover property (st_r.state == S_SHUTDOWN ##1 state_r == S_STOPPED);

endmodule

// >>> testbench/lin_master_model.sv
// bus master model issuing one-cycle command strobes
`timescale 1ns/1ps
`include "motion_consts.svh"

module lin_master_model
	import motion_pkg::*;
(
	// clock
	input  wire logic              sys_clk,
	// command strobes toward the encoder
	output cmd_s                   cmd,
	output logic [`POS_W-1:0]      cmd_position
);

	// idle bus at time zero
	initial begin
		cmd = '0;
		cmd_position = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// one command after gap plus one idle cycles, operand inverted once released
	task automatic send(input int bit_no, input logic [`POS_W-1:0] pos, input int gap);
		repeat (gap) @(negedge sys_clk);
		@(negedge sys_clk);
		cmd <= cmd_s'(14'h1 << bit_no);
		cmd_position <= pos;
		@(negedge sys_clk);
		cmd <= '0;
		cmd_position <= ~pos;
	endtask

endmodule

// >>> testbench/motion_state_priority_encoder_tb_top.sv
// self-checking bench of the motion state priority encoder
`timescale 1ns/1ps
`include "motion_consts.svh"

module motion_state_priority_encoder_tb_top
	import motion_pkg::*;
;
	// strobe bit positions inside cmd_s
	localparam int WT = 13, WTS = 12, GS = 11, RR = 10, FH = 9, DH = 8, SL = 7;
	localparam int TO = 6, RS = 5, RFS = 4, RD = 3, WMP = 2, CP = 1, AI = 0;

	// stimulus
	logic               sys_clk, reset, half_step_mode, motion_done, run_second_motion;
	cmd_s               cmd;
	logic [`POS_W-1:0]  cmd_position, current_position;
	run_cmd_s           run_cmd;
	logic [`SAFE_W-1:0] safe_target;
	params_s            ram_params;
	logic               ram_profile_select, cp_fail_pin, low_battery_pin;
	logic               elec_defect_pin, over_temp_pin, wake_pin;
	// observed outputs
	motion_state_e      state_r;
	logic [`POS_W-1:0]  goal_position_r;
	logic               sleep_flag_r, stop_flag_r, fault_halt_flag_r, over_temp_flag_r;
	logic               step_loss_flag_r, power_on_flag_r, safe_target_valid_r;
	logic               clear_current_r, id_assign_r, ramp_profile_select_r;
	params_s            run_params_r, active_params_r;
	int                 mismatches = 0;
	int                 n_checks = 0;

	////////////////////////////////////////////////////////////////////////////
	// design and master model
	motion_state_priority_encoder i_dut (.sys_clk, .reset, .cmd, .cmd_position, .run_cmd,
		.half_step_mode, .current_position, .motion_done, .run_second_motion,
		.safe_target, .ram_params, .ram_profile_select, .cp_fail_pin, .low_battery_pin,
		.elec_defect_pin, .over_temp_pin, .wake_pin, .state_r, .goal_position_r,
		.sleep_flag_r, .stop_flag_r, .fault_halt_flag_r, .over_temp_flag_r,
		.step_loss_flag_r, .power_on_flag_r, .safe_target_valid_r, .clear_current_r,
		.id_assign_r, .ramp_profile_select_r, .run_params_r, .active_params_r);

	lin_master_model m (.sys_clk, .cmd, .cmd_position);

	// 40 MHz clock
	initial begin
		sys_clk = 0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	// compare tasks and helpers
	task automatic chk(input logic [`POS_W-1:0] got, input logic [`POS_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkb(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// state compare after at most n settling cycles
	task automatic st(input motion_state_e exp, input int n = 0);
		for (int i = 0; i < n && state_r !== exp; i++) begin
			@(negedge sys_clk);
		end
		n_checks++;
		if (state_r !== exp) begin
			mismatches++;
			$display("unexpected state at %0t: got %h exp %h", $time, state_r, exp);
		end
	endtask

	task automatic op(input int b, input logic [`POS_W-1:0] p = '0, input int gap = 0);
		m.send(b, p, gap);
	endtask

	task automatic done_at(input logic [`POS_W-1:0] pos);
		current_position = pos;
		@(negedge sys_clk) motion_done = 1;
		@(negedge sys_clk) motion_done = 0;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog: the sequence needs little more than a hundred cycles
	initial begin
		#(3000 * 25);
		mismatches++;
		results();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		reset = 1;
		half_step_mode = 0;
		current_position = '0;
		motion_done = 0;
		run_second_motion = 0;
		safe_target = `SAFE_DISABLED;
		ram_params = 12'h567;
		ram_profile_select = 0;
		run_cmd = 10'h320;
		{cp_fail_pin, low_battery_pin, elec_defect_pin, over_temp_pin, wake_pin} = '0;
		repeat (6) @(negedge sys_clk);
		reset = 0;
		st(S_SHUTDOWN);
		chkb(power_on_flag_r, 1'b1);
		chk(goal_position_r, `GOAL_RESET);
		op(RS);
		st(S_SHUTDOWN);
		op(RFS);
		st(S_STOPPED);
		chkb(power_on_flag_r, 1'b0);
		chkb(safe_target_valid_r, 1'b0);
		safe_target = 11'h012;
		op(AI, '0, 2);
		chkb(id_assign_r, 1'b1);
		chkb(safe_target_valid_r, 1'b1);
		st(S_STOPPED);
		op(CP);
		chkb(clear_current_r, 1'b1);
		chk(goal_position_r, 16'h0000);
		op(GS);
		st(S_MOVING_TO_TARGET);
		chk(goal_position_r, 16'h0240);
		op(WT, 16'h0100);
		chk(16'(active_params_r), 16'h0567);
		op(WTS, 16'h0200);
		chk(goal_position_r, 16'h0100);
		half_step_mode = 1;
		op(WTS, 16'h0200);
		chk(goal_position_r, 16'h0200);
		op(TO);
		chk(goal_position_r, 16'h0240);
		chkb(sleep_flag_r, 1'b1);
		op(AI);
		chkb(sleep_flag_r, 1'b0);
		op(DH);
		st(S_DECELERATING_HALT);
		done_at(16'h0123);
		st(S_STOPPED);
		chk(goal_position_r, 16'h0123);
		chkb(stop_flag_r, 1'b1);
		@(negedge sys_clk);
		chkb(stop_flag_r, 1'b0);
		current_position = 16'h0150;
		st(S_MOVING_TO_TARGET, 3);
		op(FH);
		st(S_FORCED_HALT);
		chkb(step_loss_flag_r, 1'b1);
		done_at(16'h0150);
		op(WT, 16'h0777);
		chk(goal_position_r, 16'h0150);
		op(RS);
		chkb(step_loss_flag_r, 1'b0);
		op(RR);
		st(S_REFERENCE_RUN);
		chk(16'(run_params_r), 16'h0967);
		op(DH);
		st(S_REFERENCE_RUN);
		ram_params = 12'h123;
		op(WMP);
		chk(16'(active_params_r), 16'h0567);
		run_second_motion = 1;
		op(RD);
		chkb(ramp_profile_select_r, 1'b1);
		op(SL);
		st(S_REFERENCE_RUN);
		chk(goal_position_r, 16'h0240);
		run_second_motion = 0;
		done_at(16'h0150);
		st(S_MOVING_TO_TARGET, 3);
		chk(goal_position_r, 16'h0240);
		chkb(ramp_profile_select_r, 1'b0);
		done_at(16'h0240);
		st(S_SLEEP, 3);
		wake_pin = 1;
		st(S_SHUTDOWN, 6);
		chkb(power_on_flag_r, 1'b1);
		chk(goal_position_r, `GOAL_RESET);
		wake_pin = 0;
		current_position = '0;
		op(RFS, '0, 3);
		st(S_STOPPED);
		op(WT, 16'h0010);
		st(S_MOVING_TO_TARGET);
		chk(16'(active_params_r), 16'h0123);
		safe_target = `SAFE_DISABLED;
		op(SL, '0, 2);
		st(S_DECELERATING_HALT);
		op(AI);
		chkb(sleep_flag_r, 1'b0);
		done_at(16'h0010);
		op(WT, 16'h0020);
		over_temp_pin = 1;
		st(S_DECELERATING_HALT, 6);
		chkb(over_temp_flag_r, 1'b1);
		done_at(16'h0020);
		st(S_SHUTDOWN, 3);
		op(RFS);
		st(S_SHUTDOWN);
		over_temp_pin = 0;
		op(RFS, '0, 3);
		st(S_STOPPED);
		chkb(over_temp_flag_r, 1'b0);
		low_battery_pin = 1;
		st(S_SHUTDOWN, 6);
		chkb(fault_halt_flag_r, 1'b1);
		low_battery_pin = 0;
		op(RFS, '0, 3);
		st(S_STOPPED);
		chkb(fault_halt_flag_r, 1'b0);
		op(WT, 16'h0030);
		elec_defect_pin = 1;
		st(S_FORCED_HALT, 6);
		elec_defect_pin = 0;
		op(RS, '0, 3);
		chkb(fault_halt_flag_r, 1'b0);
		results();
	end

endmodule
